// *** verilog/cbk_pkg.sv ***
package cbk_pkg;
  localparam int CLK_HZ = 10000000;
  localparam int SCL_HZ = 100000;
  localparam int QTR_CYC = CLK_HZ / (4 * SCL_HZ);
  localparam logic [7:0] QTR_LOAD = 8'(QTR_CYC - 1);
  localparam logic [6:0] DEV_ADDR = 7'h36;
  localparam logic [7:0] SUB_BANK = 8'h50;
  localparam logic [7:0] SUB_CF_LO = 8'h29;
  localparam logic [7:0] SUB_BQ_HI = 8'h38;
  localparam logic [7:0] SUB_CF_HI = 8'h3F;
  localparam int CF_W = 26;
  localparam int CF_SUBS = 23;
  localparam int CF_WORDS = 5;
  localparam logic [4:0] BQ_BYTES = 5'h14;
  localparam logic [4:0] MIX_BYTES = 5'h04;
  localparam logic [4:0] REG_BYTES = 5'h01;
  localparam logic [2:0] BANK_AUTO = 3'h4;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [2:0] OFF_DATA_HI = 3'h1;
  localparam int CTL_GO = 0;
  localparam int CTL_RD = 1;
  localparam int CTL_CNT_LSB = 8;
  localparam int CTL_SUB_LSB = 16;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  // Bytes that make one complete write set at a subaddress
  function automatic logic [4:0] cbk_need(input logic [7:0] sub);
    if (sub >= SUB_CF_LO && sub <= SUB_BQ_HI) begin
      return BQ_BYTES;
    end
    if (sub > SUB_BQ_HI && sub <= SUB_CF_HI) begin
      return MIX_BYTES;
    end
    return REG_BYTES;
  endfunction

  // Byte b of a word, byte 0 being the most significant
  function automatic logic [7:0] cbk_byte(input logic [31:0] w, input logic [1:0] b);
    return 8'(w >> {~b, 3'b000});
  endfunction
endpackage

// *** verilog/cbk_i2c_if.sv ***
`timescale 1ns/100ps
interface cbk_i2c_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;
  // Wired-AND with pull-ups
  assign scl = !(m_scl_oe && !m_scl_o);
  assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));
  modport master (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe, input scl, sda);
  modport slave (output s_sda_o, s_sda_oe, input scl, sda);
endinterface

// *** verilog/cbk_i2c_slave.sv ***
// Behaviour
// - Byte access to registers, 4-byte to coefficients
// - Read streams successive bytes while master acknowledges
// - Unused upper bits of short words read zero
// - Filter write needs five words, else discarded
// - Mixer coefficient write needs exactly one word
// - Sequential write fills successive subaddresses
// - Only the incomplete final set is dropped
// - Write: start, address+0, subaddress, data, stop
// - Every received data byte is acknowledged
// - Read: subaddress write, repeated start, address+1
// - Master acknowledges all but last, then stop
// - Three stored banks: 32k, 44.1/48k, others
// - Select 000: coefficient writes go to core
// - Select 001-011: writes update stored bank
// - Select 100: bank follows detected sample rate
// - Controller loads banks before selecting 100
// - Each filter holds five 26-bit coefficients
// - Headphone mode bypasses equalizer and compressor
// - Slave address is 0x36
// - Slave only, never stretches the clock
`timescale 1ns/100ps
module cbk_i2c_slave
  import cbk_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  cbk_i2c_if.slave bus,
  input wire logic [1:0] rate_class,
  input wire logic hp_mode,
  output logic [1:0] active_bank,
  output logic eq_bypass,
  output logic drc_bypass
);
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_RX = 5'b00010,
    S_ACK = 5'b00100,
    S_TX = 5'b01000,
    S_RACK = 5'b10000
  } cbk_sst_t;

  cbk_sst_t st_q;
  logic scl_q;
  logic sda_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic [1:0] ph_q;
  logic rw_q;
  logic [7:0] sub_q;
  logic [4:0] bcnt_q;
  logic oe_q;
  logic [31:0] wbuf_q [CF_WORDS];
  logic [CF_W-1:0] cf_q [4][CF_SUBS][CF_WORDS];
  logic [7:0] reg_q [256];
  logic [1:0] act_q;
  logic eqb_q;
  logic drcb_q;

  wire logic scl = bus.scl;
  wire logic sda = bus.sda;
  wire logic scl_rise = scl && !scl_q;
  wire logic scl_fall = !scl && scl_q;
  wire logic start_c = scl && scl_q && sda_q && !sda;
  wire logic stop_c = scl && scl_q && !sda_q && sda;
  wire logic [4:0] need = cbk_need(sub_q);
  wire logic last_c = bcnt_q == 5'(need - 5'h01);
  wire logic is_cf = need != REG_BYTES;
  wire logic [4:0] cidx = 5'(sub_q - SUB_CF_LO);
  wire logic [2:0] widx = bcnt_q[4:2];
  wire logic [2:0] sel = reg_q[SUB_BANK][2:0];
  wire logic upd = sel != 3'h0 && sel < BANK_AUTO;
  wire logic [1:0] wbank = upd ? sel[1:0] : 2'h0;
  wire logic [1:0] rbank = (sel == BANK_AUTO) ? act_q : wbank;
  wire logic [31:0] rd_word = {6'h00, cf_q[rbank][cidx][widx]};
  wire logic [7:0] reg_rd = (sub_q == SUB_BANK) ? {5'h00, sel} : reg_q[sub_q];
  wire logic [7:0] rd_byte = is_cf ? cbk_byte(rd_word, bcnt_q[1:0]) : reg_rd;
  wire logic byte_done = st_q == S_RX && scl_fall && bit_q == 4'h8;
  wire logic addr_ok = sh_q[7:1] == DEV_ADDR;
  wire logic wr_byte = byte_done && ph_q == 2'h2;
  wire logic [1:0] rate_bank = (rate_class == 2'h0) ? 2'h1 : (rate_class == 2'h1) ? 2'h2 : 2'h3;

  // Slave never drives SCL and drives SDA only low
  assign bus.s_sda_o = 1'b0;
  assign bus.s_sda_oe = oe_q;
  assign active_bank = act_q;
  assign eq_bypass = eqb_q;
  assign drc_bypass = drcb_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= S_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      ph_q <= 2'h0;
      rw_q <= 1'b0;
      sub_q <= 8'h00;
      bcnt_q <= 5'h00;
      oe_q <= 1'b0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start_c) begin
        // Start or repeated start abandons any partial set
        st_q <= S_RX;
        bit_q <= 4'h0;
        ph_q <= 2'h0;
        bcnt_q <= 5'h00;
        oe_q <= 1'b0;
      end else if (stop_c) begin
        st_q <= S_IDLE;
        bcnt_q <= 5'h00;
        oe_q <= 1'b0;
      end else begin
        unique case (st_q)
          S_IDLE: begin
          end
          S_RX: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda};
              bit_q <= 4'(bit_q + 4'h1);
            end else if (byte_done) begin
              bit_q <= 4'h0;
              oe_q <= 1'b1;
              st_q <= S_ACK;
              if (ph_q == 2'h0) begin
                rw_q <= sh_q[0];
                ph_q <= sh_q[0] ? 2'h3 : 2'h1;
                if (!addr_ok) begin
                  oe_q <= 1'b0;
                  st_q <= S_IDLE;
                end
              end else if (ph_q == 2'h1) begin
                sub_q <= sh_q;
                bcnt_q <= 5'h00;
                ph_q <= 2'h2;
              end else if (last_c) begin
                bcnt_q <= 5'h00;
                sub_q <= 8'(sub_q + 8'h01);
              end else begin
                bcnt_q <= 5'(bcnt_q + 5'h01);
              end
            end
          end
          S_ACK: begin
            if (scl_fall && rw_q) begin
              st_q <= S_TX;
              sh_q <= {rd_byte[6:0], 1'b0};
              oe_q <= !rd_byte[7];
              bit_q <= 4'h1;
              if (last_c) begin
                bcnt_q <= 5'h00;
                sub_q <= 8'(sub_q + 8'h01);
              end else begin
                bcnt_q <= 5'(bcnt_q + 5'h01);
              end
            end else if (scl_fall) begin
              st_q <= S_RX;
              oe_q <= 1'b0;
            end
          end
          S_TX: begin
            if (scl_fall && bit_q == 4'h8) begin
              oe_q <= 1'b0;
              st_q <= S_RACK;
            end else if (scl_fall) begin
              oe_q <= !sh_q[7];
              sh_q <= {sh_q[6:0], 1'b0};
              bit_q <= 4'(bit_q + 4'h1);
            end
          end
          S_RACK: begin
            if (scl_rise) begin
              st_q <= sda ? S_IDLE : S_ACK;
            end
          end
        endcase
      end
    end
  end

  // Byte-wide registers, bank select among them
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 256; i++) begin
        reg_q[i] <= REG_RST;
      end
    end else if (wr_byte && !is_cf) begin
      reg_q[sub_q] <= sh_q;
    end
  end

  // Collect bytes of a coefficient set
  always_ff @(posedge clk) begin
    if (wr_byte && is_cf) begin
      wbuf_q[widx][{~bcnt_q[1:0], 3'b000} +: 8] <= sh_q;
    end
  end

  // Commit only a complete set; bank 0 is the core
  always_ff @(posedge clk) begin
    if (wr_byte && is_cf && last_c) begin
      for (int k = 0; k < CF_WORDS; k++) begin
        if (k < int'(widx)) begin
          cf_q[wbank][cidx][k] <= wbuf_q[k][CF_W-1:0];
        end else if (k == int'(widx)) begin
          cf_q[wbank][cidx][k] <= {wbuf_q[k][CF_W-1:8], sh_q};
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      act_q <= 2'h0;
      eqb_q <= 1'b0;
      drcb_q <= 1'b0;
    end else begin
      act_q <= (sel == BANK_AUTO) ? rate_bank : 2'h0;
      eqb_q <= hp_mode;
      drcb_q <= hp_mode;
    end
  end
endmodule // cbk_i2c_slave

// *** verilog/cbk_i2c_host.sv ***
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps
module cbk_i2c_host
  import cbk_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  cbk_i2c_if.master bus,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef enum logic [3:0] {
    M_IDLE = 4'b0001,
    M_START = 4'b0010,
    M_BIT = 4'b0100,
    M_STOP = 4'b1000
  } cbk_mst_t;

  cbk_mst_t st_q;
  logic [7:0] div_q;
  logic [1:0] qtr_q;
  logic [3:0] bit_q;
  logic [7:0] tx_q;
  logic [7:0] rx_q;
  logic [1:0] ph_q;
  logic rxm_q;
  logic [5:0] idx_q;
  logic [5:0] cnt_q;
  logic rd_q;
  logic [7:0] sub_q;
  logic busy_q;
  logic nack_q;
  logic scl_oe_q;
  logic sda_oe_q;
  logic [31:0] data_q [8];
  logic awr_q;
  logic wr_q;
  logic bv_q;
  logic [1:0] br_q;
  logic arr_q;
  logic rv_q;
  logic [1:0] rr_q;
  logic [31:0] rdat_q;
  logic [7:0] wa_q;
  logic [31:0] wd_q;
  logic [3:0] ws_q;

  wire logic tick = div_q == 8'h00;
  wire logic last = idx_q == 6'(cnt_q - 6'h01);
  wire logic [7:0] tx_cur = cbk_byte(data_q[idx_q[4:2]], idx_q[1:0]);
  wire logic [5:0] idx_nx = 6'(idx_q + 6'h01);
  wire logic [7:0] tx_nx = cbk_byte(data_q[idx_nx[4:2]], idx_nx[1:0]);
  wire logic do_wr = !awr_q && !wr_q && !bv_q;
  wire logic w_data = wa_q[7:5] == OFF_DATA_HI && wa_q[1:0] == 2'h0;
  wire logic w_hit = w_data || wa_q == OFF_CTRL;
  wire logic go = do_wr && wa_q == OFF_CTRL && ws_q[0] && wd_q[CTL_GO] && !busy_q;
  wire logic r_data = s_axi_araddr[7:5] == OFF_DATA_HI && s_axi_araddr[1:0] == 2'h0;
  wire logic r_stat = s_axi_araddr == OFF_STAT;
  wire logic r_ctrl = s_axi_araddr == OFF_CTRL;
  wire logic [31:0] ctrl_rd = {8'h00, sub_q, 2'h0, cnt_q, 6'h00, rd_q, 1'b0};
  wire logic [31:0] rd_val = r_stat ? {30'h0, nack_q, busy_q} : r_ctrl ? ctrl_rd :
    r_data ? data_q[s_axi_araddr[4:2]] : 32'h0000_0000;
  wire logic bit_end = st_q == M_BIT && tick && qtr_q == 2'h3 && bit_q == 4'h8;

  assign bus.m_scl_o = 1'b0;
  assign bus.m_scl_oe = scl_oe_q;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_sda_oe = sda_oe_q;
  assign s_axi_awready = awr_q;
  assign s_axi_wready = wr_q;
  assign s_axi_bvalid = bv_q;
  assign s_axi_bresp = br_q;
  assign s_axi_arready = arr_q;
  assign s_axi_rvalid = rv_q;
  assign s_axi_rresp = rr_q;
  assign s_axi_rdata = rdat_q;

  // AXI4-Lite slave, one write and one read at a time
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      awr_q <= 1'b1;
      wr_q <= 1'b1;
      bv_q <= 1'b0;
      br_q <= RESP_OK;
      arr_q <= 1'b1;
      rv_q <= 1'b0;
      rr_q <= RESP_OK;
      rdat_q <= 32'h0000_0000;
      wa_q <= 8'h00;
      wd_q <= 32'h0000_0000;
      ws_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && awr_q) begin
        wa_q <= s_axi_awaddr;
        awr_q <= 1'b0;
      end
      if (s_axi_wvalid && wr_q) begin
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
        wr_q <= 1'b0;
      end
      if (do_wr) begin
        bv_q <= 1'b1;
        br_q <= w_hit ? RESP_OK : RESP_ERR;
      end else if (bv_q && s_axi_bready) begin
        bv_q <= 1'b0;
        awr_q <= 1'b1;
        wr_q <= 1'b1;
      end
      if (s_axi_arvalid && arr_q) begin
        arr_q <= 1'b0;
        rv_q <= 1'b1;
        rdat_q <= rd_val;
        rr_q <= (r_data || r_stat || r_ctrl) ? RESP_OK : RESP_ERR;
      end else if (rv_q && s_axi_rready) begin
        rv_q <= 1'b0;
        arr_q <= 1'b1;
      end
    end
  end

  // Data words: software writes, received bytes land here too
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 8; i++) begin
        data_q[i] <= 32'h0000_0000;
      end
    end else if (bit_end && rxm_q) begin
      data_q[idx_q[4:2]][{~idx_q[1:0], 3'b000} +: 8] <= rx_q;
    end else if (do_wr && w_data) begin
      for (int b = 0; b < 4; b++) begin
        if (ws_q[b]) begin
          data_q[wa_q[4:2]][8*b +: 8] <= wd_q[8*b +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= M_IDLE;
      div_q <= QTR_LOAD;
      qtr_q <= 2'h0;
      bit_q <= 4'h0;
      tx_q <= 8'h00;
      rx_q <= 8'h00;
      ph_q <= 2'h0;
      rxm_q <= 1'b0;
      idx_q <= 6'h00;
      cnt_q <= 6'h00;
      rd_q <= 1'b0;
      sub_q <= 8'h00;
      busy_q <= 1'b0;
      nack_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      div_q <= tick ? QTR_LOAD : 8'(div_q - 8'h01);
      if (go) begin
        busy_q <= 1'b1;
        nack_q <= 1'b0;
        rd_q <= wd_q[CTL_RD];
        cnt_q <= wd_q[CTL_CNT_LSB +: 6];
        sub_q <= wd_q[CTL_SUB_LSB +: 8];
        tx_q <= {DEV_ADDR, 1'b0};
        ph_q <= 2'h0;
        idx_q <= 6'h00;
        rxm_q <= 1'b0;
        qtr_q <= 2'h0;
        bit_q <= 4'h0;
        st_q <= M_START;
      end else if (tick && st_q != M_IDLE) begin
        qtr_q <= 2'(qtr_q + 2'h1);
        unique case (st_q)
          M_IDLE: begin
          end
          M_START: begin
            if (qtr_q == 2'h0) sda_oe_q <= 1'b0;
            if (qtr_q == 2'h1) scl_oe_q <= 1'b0;
            if (qtr_q == 2'h2) sda_oe_q <= 1'b1;
            if (qtr_q == 2'h3) begin
              scl_oe_q <= 1'b1;
              bit_q <= 4'h0;
              st_q <= M_BIT;
            end
          end
          M_BIT: begin
            if (qtr_q == 2'h0) begin
              if (bit_q != 4'h8) sda_oe_q <= !rxm_q && !tx_q[7];
              else sda_oe_q <= rxm_q && !last;
            end
            if (qtr_q == 2'h1) scl_oe_q <= 1'b0;
            if (qtr_q == 2'h2) begin
              if (bit_q != 4'h8) rx_q <= {rx_q[6:0], bus.sda};
              else if (!rxm_q) nack_q <= nack_q || bus.sda;
            end
            if (qtr_q == 2'h3) begin
              scl_oe_q <= 1'b1;
              if (bit_q != 4'h8) begin
                tx_q <= {tx_q[6:0], 1'b0};
                bit_q <= 4'(bit_q + 4'h1);
              end else begin
                bit_q <= 4'h0;
                if (rxm_q) begin
                  if (last) st_q <= M_STOP;
                  else idx_q <= idx_nx;
                end else if (nack_q) begin
                  st_q <= M_STOP;
                end else begin
                  unique case (ph_q)
                    2'h0: begin
                      tx_q <= sub_q;
                      ph_q <= 2'h1;
                    end
                    2'h1: begin
                      if (cnt_q == 6'h00) begin
                        st_q <= M_STOP;
                      end else if (rd_q) begin
                        tx_q <= {DEV_ADDR, 1'b1};
                        ph_q <= 2'h2;
                        st_q <= M_START;
                      end else begin
                        tx_q <= tx_cur;
                        ph_q <= 2'h3;
                      end
                    end
                    2'h2: begin
                      rxm_q <= 1'b1;
                      ph_q <= 2'h3;
                    end
                    2'h3: begin
                      if (last) begin
                        st_q <= M_STOP;
                      end else begin
                        idx_q <= idx_nx;
                        tx_q <= tx_nx;
                      end
                    end
                  endcase
                end
              end
            end
          end
          M_STOP: begin
            if (qtr_q == 2'h0) sda_oe_q <= 1'b1;
            if (qtr_q == 2'h1) scl_oe_q <= 1'b0;
            if (qtr_q == 2'h2) sda_oe_q <= 1'b0;
            if (qtr_q == 2'h3) begin
              busy_q <= 1'b0;
              st_q <= M_IDLE;
            end
          end
        endcase
      end
    end
  end
endmodule // cbk_i2c_host

// *** verification/cbk_i2c_props.sv ***
`timescale 1ns/100ps
module cbk_i2c_props
  import cbk_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl,
  input wire logic sda,
  input wire logic s_sda_oe,
  input wire logic [1:0] rate_class,
  input wire logic hp_mode,
  input wire logic [1:0] active_bank,
  input wire logic eq_bypass,
  input wire logic drc_bypass
);
  logic scl_q;
  logic sda_q;
  logic [7:0] sh_q;
  logic [3:0] cnt_q;
  logic first_q;
  logic wr_q;
  wire scl_rise = scl && !scl_q;
  wire start_det = scl && scl_q && sda_q && !sda;
  wire stop_det = scl && scl_q && !sda_q && sda;
  wire ninth = scl_rise && cnt_q == 4'h8;
  wire addr_hit = sh_q[7:1] == DEV_ADDR;

  // Bit position within the current byte, and whether a write phase is open
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sh_q <= 8'h00;
      cnt_q <= 4'h0;
      first_q <= 1'b0;
      wr_q <= 1'b0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start_det) begin
        cnt_q <= 4'h0;
        first_q <= 1'b1;
        wr_q <= 1'b0;
      end else if (scl_rise) begin
        sh_q <= {sh_q[6:0], sda};
        cnt_q <= ninth ? 4'h0 : cnt_q + 4'h1;
        if (ninth && first_q) begin
          first_q <= 1'b0;
          wr_q <= addr_hit && !sh_q[0];
        end
      end
    end
  end

  function automatic logic [1:0] bank_of(input logic [1:0] r);
    return (r == 2'h0) ? 2'h1 : (r == 2'h1) ? 2'h2 : 2'h3;
  endfunction

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_sda_low_phase; $changed(s_sda_oe) |-> !scl; endproperty
  a_sda_low_phase: assert property (p_sda_low_phase)
    else $error("slave data changed while clock high");
  property p_addr_ack; ninth && first_q && addr_hit |-> !sda; endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("own address not acknowledged");
  property p_wr_ack; ninth && !first_q && wr_q |-> !sda; endproperty
  a_wr_ack: assert property (p_wr_ack)
    else $error("written byte not acknowledged");
  property p_read_release; ninth && !first_q && !wr_q |-> !s_sda_oe; endproperty
  a_read_release: assert property (p_read_release)
    else $error("slave holds data line in master acknowledge slot");
  property p_bypass;
    $past(rstn) |-> eq_bypass == $past(hp_mode) && drc_bypass == $past(hp_mode);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass does not follow headphone mode");
  property p_bank_map; active_bank != 2'h0 |-> active_bank == bank_of($past(rate_class)); endproperty
  a_bank_map: assert property (p_bank_map)
    else $error("active bank does not match sample rate");
  property p_bank_hold;
    active_bank != 2'h0 && $stable(rate_class) |=> active_bank == 2'h0 || $stable(active_bank);
  endproperty
  a_bank_hold: assert property (p_bank_hold)
    else $error("bank changed without rate change");
  property p_quiet_stop; stop_det |-> (!s_sda_oe) [*4]; endproperty
  a_quiet_stop: assert property (p_quiet_stop)
    else $error("slave drives data line after stop");

  c_wr_ack: cover property (ninth && wr_q);
  c_read: cover property (ninth && !first_q && !wr_q);
  c_auto_bank: cover property (active_bank == 2'h3);
endmodule // cbk_i2c_props

// *** verification/i2c_coef_port_bank_switch_tb_top.sv ***
`timescale 1ns/100ps
module i2c_coef_port_bank_switch_tb_top
  import cbk_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [1:0] rate_class = 2'h0;
  logic hp_mode = 1'b0;
  logic [1:0] active_bank;
  logic eq_bypass, drc_bypass;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] rd_w;
  logic [1:0] rsp;
  int bad_count = 0;
  int checks_done = 0;

  cbk_i2c_if bus();

  always #50 clk = ~clk;

  cbk_i2c_slave i_cbk_i2c_slave (.clk(clk), .rstn(rstn), .bus(bus), .rate_class(rate_class),
    .hp_mode(hp_mode), .active_bank(active_bank), .eq_bypass(eq_bypass),
    .drc_bypass(drc_bypass));
  cbk_i2c_host i_cbk_i2c_host (.clk(clk), .rstn(rstn), .bus(bus),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  cbk_i2c_props i_cbk_i2c_props (.clk(clk), .rstn(rstn), .scl(bus.scl), .sda(bus.sda),
    .s_sda_oe(bus.s_sda_oe), .rate_class(rate_class), .hp_mode(hp_mode),
    .active_bank(active_bank), .eq_bypass(eq_bypass), .drc_bypass(drc_bypass));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic got;
    got = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!got) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        got = 1'b1;
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic got;
    got = 1'b0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!got) begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        got = 1'b1;
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
  endtask

  task automatic put(input int n, input logic [31:0] w);
    axi_wr(8'(8'h20 + 4 * n), w, rsp);
    check("data write response", {30'h0, rsp}, {30'h0, RESP_OK});
  endtask

  task automatic get(input int n, output logic [31:0] w);
    axi_rd(8'(8'h20 + 4 * n), w, rsp);
  endtask

  // Start one link transfer and poll until it has finished
  task automatic xfer(input logic [7:0] sub, input logic [5:0] cnt, input logic rd);
    axi_wr(OFF_CTRL, {8'h00, sub, 2'b00, cnt, 6'h00, rd, 1'b1}, rsp);
    rd_w = 32'h1;
    while (rd_w[0] !== 1'b0)
      axi_rd(OFF_STAT, rd_w, rsp);
    check("link nack", {31'h0, rd_w[1]}, 32'h0);
    check("idle lines", {30'h0, bus.scl, bus.sda}, 32'h3);
  endtask

  task automatic set_bank(input logic [2:0] sel);
    put(0, {5'h00, sel, 24'h0});
    xfer(SUB_BANK, 6'h01, 1'b0);
  endtask

  task automatic t_misc;
    check("bank after reset", {30'h0, active_bank}, 32'h0);
    axi_wr(8'hF0, 32'h1, rsp);
    check("unmapped write", {30'h0, rsp}, {30'h0, RESP_ERR});
    axi_rd(8'hF0, rd_w, rsp);
    check("unmapped read resp", {30'h0, rsp}, {30'h0, RESP_ERR});
    check("unmapped read data", rd_w, 32'h0);
    hp_mode <= 1'b1;
    repeat (2) @(posedge clk);
    check("bypass on", {30'h0, eq_bypass, drc_bypass}, 32'h3);
    hp_mode <= 1'b0;
    repeat (2) @(posedge clk);
    check("bypass off", {30'h0, eq_bypass, drc_bypass}, 32'h0);
    $display("test misc done");
  endtask

  task automatic t_regs;
    put(0, 32'hA53C0000);
    xfer(8'h10, 6'h02, 1'b0);
    put(0, 32'h0);
    xfer(8'h10, 6'h02, 1'b1);
    get(0, rd_w);
    check("byte registers", rd_w, 32'hA53C0000);
    $display("test regs done");
  endtask

  task automatic t_mixer;
    put(0, 32'h11111111);
    put(1, 32'h12345678);
    xfer(8'h39, 6'h08, 1'b0);
    put(0, 32'hFFFFFFFF);
    put(1, 32'hCAFE0000);
    xfer(8'h39, 6'h06, 1'b0);
    xfer(8'h39, 6'h08, 1'b1);
    get(0, rd_w);
    check("mixer word", rd_w, 32'h03FFFFFF);
    get(1, rd_w);
    check("kept after partial set", rd_w, 32'h02345678);
    $display("test mixer done");
  endtask

  task automatic t_banks;
    for (int b = 1; b < 4; b++) begin
      set_bank(3'(b));
      put(0, {8'h00, 8'(b), 16'h1234});
      xfer(8'h3E, 6'h04, 1'b0);
    end
    set_bank(BANK_AUTO);
    for (int r = 0; r < 4; r++) begin
      rate_class <= 2'(r);
      repeat (3) @(posedge clk);
      check("active bank", {30'h0, active_bank}, (r == 3) ? 32'h3 : 32'(r + 1));
      if (r < 3) begin
        xfer(8'h3E, 6'h04, 1'b1);
        get(0, rd_w);
        check("bank coefficient", rd_w, {8'h00, 8'(r + 1), 16'h1234});
      end
    end
    set_bank(3'h0);
    check("bank off", {30'h0, active_bank}, 32'h0);
    $display("test banks done");
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    t_misc;
    t_regs;
    t_mixer;
    t_banks;
    give_verdict;
  end

  initial begin
    // All tests need about 87000 cycles
    repeat (99000) @(posedge clk);
    bad_count++;
    give_verdict;
  end
endmodule // i2c_coef_port_bank_switch_tb_top
